//--- jmc_config.sv
`timescale 1ns/1ns
`include "jmc_regs.svh"


// Show-ahead FIFO built as a shift register so the head word is a flop.
module jmc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic push;
  logic pop;

  // Ready and valid are registered, so neither side sees a combinational path.
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[0];

  // Every entry shifts towards the head on a pop and loads at the tail on a push.
  generate
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_ent
      always_comb
      begin
        mem_nxt[i] = mem_r[i];
        if (pop)
        begin
          mem_nxt[i] = (i == DEPTH - 1) ? mem_r[i] : mem_r[(i + 1) % DEPTH];
        end
        if (push && (CW'(i) == cnt_r - CW'(pop)))
        begin
          mem_nxt[i] = in_data_i;
        end
      end
      always_ff @(posedge ref_clk_i or posedge rst_i)
      begin
        if (rst_i)
          mem_r[i] <= '0;
        else
          mem_r[i] <= mem_nxt[i];
      end
    end
  endgenerate

  // Occupancy count; full and empty flags are flops loaded from the next count, so they match it in the same cycle.
  always_comb
  begin
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      in_ready_o <= (cnt_nxt != CW'(DEPTH));
      out_valid_o <= (cnt_nxt != '0);
    end
  end

  // The ready flop lags reset release by one edge, so the edge right after it is skipped.
  chk_fifo_bound: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> cnt_r <= CW'(DEPTH) && (in_ready_o == (cnt_r != CW'(DEPTH))))
    else $error("FIFO count out of range or ready flag wrong");
endmodule

// Mode decoder, alignment parameter set and sample path for the transmit side.
module jmc_config #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire jmc_pkg::jmc_pair_t ain_i,
  input wire jmc_pkg::jmc_pair_t bin_i,
  input wire logic samp_valid_i,
  output logic samp_ready_o,
  output logic [23:0] lane_data_o,
  output logic lane_valid_o,
  input wire logic lane_ready_i,
  input wire logic ilas_rd_i,
  input wire logic ilas_link_i,
  input wire logic [2:0] ilas_lane_i,
  input wire logic [3:0] ilas_idx_i,
  output logic [7:0] ilas_octet_o,
  output logic ilas_valid_o,
  output logic [15:0] lane_en_o,
  output logic des_o,
  output logic ddc_en_o,
  output logic [4:0] decim_o,
  output logic [4:0] serdes_mult_o,
  output logic pll_bypass_o
);
  import jmc_pkg::*;

  jmc_regreq_t req; // Bundled register access.
  logic [4:0] mode_r, mode_nxt; // Operating mode selector.
  logic [4:0] klen_r, klen_nxt; // Multiframe length field, K minus one.
  logic [7:0] devid_r, devid_nxt; // Device identifier sent in the alignment.
  logic [1:0] linkctl_r, linkctl_nxt; // Scrambler enable and link enable.
  logic [1:0] inmux_r, inmux_nxt; // Input swap and single input select.
  logic [31:0] rdata_nxt;
  jmc_mode_t cur; // Parameters of the selected mode.
  logic [5:0] k_val; // True multiframe length.
  logic k_legal; // K is allowed for this mode.
  logic [15:0] lane_en_nxt;
  logic [7:0] octet_nxt;
  logic [7:0] sum_l0; // Checksum for lane 0 of the first link.
  logic [14:0] scr_r, scr_nxt; // Scrambler history.
  jmc_pair_t word_w; // Routed samples before scrambling.
  logic [23:0] fifo_in;
  logic fifo_in_valid;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // Mode table; an unlisted code is reported invalid and turns the lanes off.
  // mode derives parameters
  function automatic jmc_mode_t decode(input logic [4:0] md);
    jmc_mode_t t;
    t = '0;
    t.valid = 1'b1;
    t.links = 2'd2;
    t.decim = 5'd1;
    case (md)
      5'd0: t = '{1'b1, 1'b1, 5'd1, 2'd2, 5'd12, 2'd0, 5'd12, 4'd4, 4'd4, 4'd8, 4'd5, 5'd16, 6'd3, 2'd1};
      5'd1: t = '{1'b1, 1'b1, 5'd1, 2'd2, 5'd12, 2'd0, 5'd12, 4'd8, 4'd8, 4'd8, 4'd5, 5'd8, 6'd3, 2'd1};
      5'd2: t = '{1'b1, 1'b0, 5'd1, 2'd2, 5'd12, 2'd0, 5'd12, 4'd4, 4'd4, 4'd8, 4'd5, 5'd16, 6'd3, 2'd1};
      5'd3: t = '{1'b1, 1'b0, 5'd1, 2'd2, 5'd12, 2'd0, 5'd12, 4'd8, 4'd8, 4'd8, 4'd5, 5'd8, 6'd3, 2'd1};
      5'd4: t = '{1'b1, 1'b1, 5'd1, 2'd2, 5'd8, 2'd0, 5'd8, 4'd2, 4'd1, 4'd1, 4'd2, 5'd20, 6'd18, 2'd2};
      5'd5: t = '{1'b1, 1'b1, 5'd1, 2'd2, 5'd8, 2'd0, 5'd8, 4'd4, 4'd1, 4'd1, 4'd4, 5'd10, 6'd18, 2'd2};
      5'd6: t = '{1'b1, 1'b0, 5'd1, 2'd2, 5'd8, 2'd0, 5'd8, 4'd2, 4'd1, 4'd1, 4'd2, 5'd20, 6'd18, 2'd2};
      5'd7: t = '{1'b1, 1'b0, 5'd1, 2'd2, 5'd8, 2'd0, 5'd8, 4'd4, 4'd1, 4'd1, 4'd4, 5'd10, 6'd18, 2'd2};
      5'd9: t = '{1'b1, 1'b0, 5'd2, 2'd2, 5'd15, 2'd1, 5'd16, 4'd4, 4'd1, 4'd2, 4'd4, 5'd10, 6'd9, 2'd1};
      5'd10: t = '{1'b1, 1'b0, 5'd4, 2'd2, 5'd15, 2'd1, 5'd16, 4'd2, 4'd2, 4'd2, 4'd1, 5'd20, 6'd9, 2'd1};
      5'd11: t = '{1'b1, 1'b0, 5'd4, 2'd2, 5'd15, 2'd1, 5'd16, 4'd4, 4'd2, 4'd2, 4'd2, 5'd10, 6'd9, 2'd1};
      5'd12: t = '{1'b1, 1'b0, 5'd4, 2'd2, 5'd12, 2'd0, 5'd12, 4'd8, 4'd8, 4'd8, 4'd5, 5'd4, 6'd3, 2'd1};
      5'd13: t = '{1'b1, 1'b0, 5'd8, 2'd2, 5'd15, 2'd1, 5'd16, 4'd1, 4'd2, 4'd4, 4'd1, 5'd20, 6'd5, 2'd1};
      5'd14: t = '{1'b1, 1'b0, 5'd8, 2'd2, 5'd15, 2'd1, 5'd16, 4'd2, 4'd2, 4'd2, 4'd1, 5'd10, 6'd9, 2'd1};
      5'd15: t = '{1'b1, 1'b0, 5'd16, 2'd1, 5'd15, 2'd1, 5'd16, 4'd1, 4'd4, 4'd8, 4'd1, 5'd20, 6'd3, 2'd1};
      5'd16: t = '{1'b1, 1'b0, 5'd16, 2'd2, 5'd15, 2'd1, 5'd16, 4'd1, 4'd2, 4'd4, 4'd1, 5'd10, 6'd5, 2'd1};
      5'd17: t = '{1'b1, 1'b1, 5'd1, 2'd2, 5'd8, 2'd0, 5'd8, 4'd8, 4'd1, 4'd1, 4'd8, 5'd5, 6'd18, 2'd2};
      5'd18: t = '{1'b1, 1'b0, 5'd1, 2'd2, 5'd8, 2'd0, 5'd8, 4'd8, 4'd1, 4'd1, 4'd8, 5'd5, 6'd18, 2'd2};
      default: t = '0;
    endcase
    return t;
  endfunction

  // One configuration octet of a lane, in the standard octet order.
  // standard octet layout
  function automatic logic [7:0] octet(input jmc_mode_t p, input logic [7:0] did, input logic [4:0] lid,
                                       input logic scr, input logic [4:0] km1, input logic [3:0] idx);
    logic [7:0] o;
    o = 8'h00;
    case (idx)
      4'd0: o = did;
      4'd1: o = 8'h00;
      4'd2: o = {3'b000, lid};
      4'd3: o = {scr, 2'b00, 5'(p.l - 4'd1)};
      4'd4: o = 8'(p.f - 4'd1);
      4'd5: o = {3'b000, km1};
      4'd6: o = 8'(p.m - 4'd1);
      4'd7: o = {3'b000, 5'(p.n - 5'd1)};
      4'd8: o = {`JMC_ILAS_SUBCLASSV, 5'(p.np - 5'd1)};
      4'd9: o = {`JMC_ILAS_JESDV, 5'(p.s - 4'd1)};
      4'd10: o = 8'h00;
      default: o = 8'h00;
    endcase
    return o;
  endfunction

  // Checksum adds every field at its own weight, not the packed octets, so SCR counts as one.
  // modulo 256 sum
  function automatic logic [7:0] chksum(input jmc_mode_t p, input logic [7:0] did, input logic [4:0] lid,
                                        input logic scr, input logic [4:0] km1);
    logic [7:0] acc;
    acc = did + 8'(lid) + 8'(scr) + 8'(p.l - 4'd1) + 8'(p.f - 4'd1) + 8'(km1) + 8'(p.m - 4'd1);
    acc = acc + 8'(p.n - 5'd1) + 8'(p.np - 5'd1) + 8'(`JMC_ILAS_SUBCLASSV) + 8'(`JMC_ILAS_JESDV);
    acc = acc + 8'(p.s - 4'd1);
    return acc;
  endfunction

  // Self-synchronous scrambler, polynomial 1 + x^14 + x^15, MSB first.
  function automatic logic [38:0] scramble(input logic [23:0] d, input logic [14:0] s);
    logic [14:0] h;
    logic [23:0] o;
    h = s;
    o = '0;
    for (int i = 23; i >= 0; i--)
    begin
      o[i] = d[i] ^ h[13] ^ h[14];
      h = {h[13:0], o[i]};
    end
    return {h, o};
  endfunction

  assign cur = decode(mode_r);
  assign k_val = 6'(klen_r) + 6'd1;

  // Report only; the host must keep K inside the mode's range and step.
  // multiframe length check
  assign k_legal = cur.valid && (k_val >= cur.kmin) && (k_val <= `JMC_MAX_K) &&
                   ((cur.kstep == 2'd1) || !(k_val[0] ^ cur.kmin[0]));
  assign sum_l0 = chksum(cur, devid_r, 5'd0, linkctl_r[`JMC_LINKCTL_SCR], klen_r);

  // Register writes and the read answer, registered one cycle later.
  always_comb
  begin
    mode_nxt = mode_r;
    klen_nxt = klen_r;
    devid_nxt = devid_r;
    linkctl_nxt = linkctl_r;
    inmux_nxt = inmux_r;
    rdata_nxt = 32'h0000_0000;
    if (req.wr)
    begin
      case (req.addr)
        `JMC_OFS_MODE: mode_nxt = req.wdata[4:0];
        `JMC_OFS_KLEN: klen_nxt = req.wdata[4:0];
        `JMC_OFS_DEVID: devid_nxt = req.wdata[7:0];
        `JMC_OFS_LINKCTL: linkctl_nxt = req.wdata[1:0];
        `JMC_OFS_INMUX: inmux_nxt = req.wdata[1:0];
        default: ; // Unmapped writes are dropped.
      endcase
    end
    if (req.rd)
    begin
      case (req.addr)
        `JMC_OFS_MODE: rdata_nxt = {27'h0, mode_r};
        `JMC_OFS_KLEN: rdata_nxt = {27'h0, klen_r};
        `JMC_OFS_DEVID: rdata_nxt = {24'h0, devid_r};
        `JMC_OFS_LINKCTL: rdata_nxt = {30'h0, linkctl_r};
        `JMC_OFS_INMUX: rdata_nxt = {30'h0, inmux_r};
        `JMC_OFS_STATUS: rdata_nxt = {13'h0, cur.r_x4, 4'h0, cur.decim, cur.links, k_legal, cur.des, cur.valid};
        `JMC_OFS_CHKSUM: rdata_nxt = {24'h0, sum_l0};
        `JMC_OFS_LANES: rdata_nxt = {16'h0, lane_en_o};
        default: rdata_nxt = 32'h0000_0000; // Unmapped reads return zero.
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_r <= `JMC_RST_MODE;
      klen_r <= `JMC_RST_KLEN;
      devid_r <= `JMC_RST_DEVID;
      linkctl_r <= `JMC_RST_LINKCTL;
      inmux_r <= `JMC_RST_INMUX;
      reg_rdata_o <= 32'h0000_0000;
    end
    else
    begin
      mode_r <= mode_nxt;
      klen_r <= klen_nxt;
      devid_r <= devid_nxt;
      linkctl_r <= linkctl_nxt;
      inmux_r <= inmux_nxt;
      reg_rdata_o <= rdata_nxt;
    end
  end

  // Lane enables: the lowest L lanes of each used link, the rest powered down.
  // lowest lanes only
  always_comb
  begin
    lane_en_nxt = 16'h0000;
    if (cur.valid && linkctl_r[`JMC_LINKCTL_EN])
    begin
      lane_en_nxt[7:0] = 8'((9'h001 << cur.l) - 9'h001);
      if (cur.links == 2'd2)
        lane_en_nxt[15:8] = lane_en_nxt[7:0];
    end
  end

  // Alignment octet for a requested lane; lane number is the lane identifier.
  // all parameters sent except CS, sent as zero
  always_comb
  begin
    if (ilas_idx_i == 4'(`JMC_ILAS_OCTETS - 1))
      octet_nxt = chksum(cur, devid_r, {2'b00, ilas_lane_i}, linkctl_r[`JMC_LINKCTL_SCR], klen_r);
    else
      octet_nxt = octet(cur, devid_r, {2'b00, ilas_lane_i}, linkctl_r[`JMC_LINKCTL_SCR], klen_r, ilas_idx_i);
  end

  // Mode-derived control outputs, all registered.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lane_en_o <= 16'h0000;
      des_o <= 1'b0;
      ddc_en_o <= 1'b0;
      decim_o <= 5'h00;
      serdes_mult_o <= 5'h00;
      pll_bypass_o <= 1'b0;
      ilas_octet_o <= 8'h00;
      ilas_valid_o <= 1'b0;
    end
    else
    begin
      lane_en_o <= lane_en_nxt;
      des_o <= cur.des;
      ddc_en_o <= cur.valid && !cur.des && (cur.decim != 5'd1);
      decim_o <= cur.decim;
      serdes_mult_o <= cur.r_x4;
      pll_bypass_o <= (cur.r_x4 == 5'd4);
      ilas_octet_o <= ilas_rd_i ? octet_nxt : 8'h00;
      ilas_valid_o <= ilas_rd_i && (ilas_idx_i < 4'(`JMC_ILAS_OCTETS)) && !ilas_link_i | (ilas_rd_i &&
                      ilas_link_i && cur.links == 2'd2 && ilas_idx_i < 4'(`JMC_ILAS_OCTETS));
    end
  end

  // Input routing: dual sends one sample of each input, single sends two of one.
  always_comb
  begin
    if (cur.des)
    begin
      word_w = inmux_r[`JMC_INMUX_SEL_B] ? bin_i : ain_i;
    end
    else
    begin
      word_w.even = inmux_r[`JMC_INMUX_SWAP] ? bin_i.even : ain_i.even;
      word_w.odd = inmux_r[`JMC_INMUX_SWAP] ? ain_i.even : bin_i.even;
    end
  end

  // Scrambling happens before buffering so the history advances only on accepted words.
  // scrambler applied
  always_comb
  begin
    fifo_in_valid = samp_valid_i && linkctl_r[`JMC_LINKCTL_EN] && cur.valid;
    scr_nxt = scr_r;
    fifo_in = word_w;
    if (linkctl_r[`JMC_LINKCTL_SCR])
    begin
      {scr_nxt, fifo_in} = scramble(word_w, scr_r);
      if (!(fifo_in_valid && samp_ready_o))
        scr_nxt = scr_r;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      scr_r <= `JMC_RST_SCR_SEED;
    else
      scr_r <= scr_nxt;
  end

  // The buffer's ready is the source's ready, so a stalled lane side backs up to the inputs.
  jmc_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(samp_ready_o),
    .in_data_i(fifo_in),
    .out_valid_o(lane_valid_o),
    .out_ready_i(lane_ready_i),
    .out_data_o(lane_data_o)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_did_read;
    ilas_rd_i && ilas_idx_i == 4'd0;
  endsequence

  chk_dual_route: assert property (!cur.des && !inmux_r[0] |-> word_w == {bin_i.even, ain_i.even})
    else $error("Dual mode routing wrong");
  chk_single_pair: assert property (cur.des && !inmux_r[1] |-> word_w == ain_i)
    else $error("Single mode does not carry both phases of input A");
  chk_swap_route: assert property (!cur.des && inmux_r[0] |-> word_w == {ain_i.even, bin_i.even})
    else $error("Input swap not applied");
  // Sampled reset keeps the edge of release, where the outputs still hold reset values, out.
  chk_ddc_single: assert property (!rst_i && cur.des |=> !ddc_en_o && des_o)
    else $error("Down-converter enabled in single-channel mode");
  chk_bypass_ratio: assert property (##1 pll_bypass_o |-> serdes_mult_o == 5'd4)
    else $error("PLL bypass without unit lane ratio");
  chk_zero_fields: assert property (ilas_rd_i && (ilas_idx_i == 4'd1 || ilas_idx_i == 4'd10 ||
    ilas_idx_i == 4'd11) |=> ilas_octet_o == 8'h00)
    else $error("Field reported nonzero");
  chk_cs_zero: assert property (ilas_rd_i && ilas_idx_i == 4'd7 |=> ilas_octet_o[7:6] == 2'b00)
    else $error("CS reported nonzero");
  chk_version_one: assert property (ilas_rd_i && ilas_idx_i == 4'd8 |=> ilas_octet_o[7:5] == 3'h1)
    else $error("Subclass field not one");
  chk_did_path: assert property (s_did_read |=> ilas_octet_o == $past(devid_r))
    else $error("Identifier octet does not follow register");
  chk_lanes_low: assert property (##1 ((lane_en_o[7:0] + 8'h01) & lane_en_o[7:0]) == 8'h00)
    else $error("Enabled lanes not lowest-indexed");
endmodule

//--- jmc_pkg.sv
package jmc_pkg;

  // Everything one operating mode fixes; counts are true values, not minus one.
  typedef struct packed {
    logic valid;
    logic des;
    logic [4:0] decim;
    logic [1:0] links;
    logic [4:0] n;
    logic [1:0] cs;
    logic [4:0] np;
    logic [3:0] l;
    logic [3:0] m;
    logic [3:0] f;
    logic [3:0] s;
    logic [4:0] r_x4;
    logic [5:0] kmin;
    logic [1:0] kstep;
  } jmc_mode_t;

  // Two 12-bit samples of one input taken in one device clock (even, odd phase).
  typedef struct packed {
    logic [11:0] odd;
    logic [11:0] even;
  } jmc_pair_t;

  // One register port access.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } jmc_regreq_t;

endpackage

//--- jmc_regs.svh
`ifndef JMC_REGS_SVH
`define JMC_REGS_SVH

// Register byte offsets on the plain register port.
`define JMC_OFS_MODE 8'h00
`define JMC_OFS_KLEN 8'h04
`define JMC_OFS_DEVID 8'h08
`define JMC_OFS_LINKCTL 8'h0C
`define JMC_OFS_INMUX 8'h10
`define JMC_OFS_STATUS 8'h14
`define JMC_OFS_CHKSUM 8'h18
`define JMC_OFS_LANES 8'h1C

// Field positions.
`define JMC_LINKCTL_SCR 0
`define JMC_LINKCTL_EN 1
`define JMC_INMUX_SWAP 0
`define JMC_INMUX_SEL_B 1

// Reset values.
`define JMC_RST_MODE 5'h00
`define JMC_RST_KLEN 5'h1F
`define JMC_RST_DEVID 8'h00
`define JMC_RST_LINKCTL 2'h0
`define JMC_RST_INMUX 2'h0
`define JMC_RST_SCR_SEED 15'h7FFF

// Fixed values sent in the alignment sequence, its octet count, and the largest K.
`define JMC_ILAS_JESDV 3'h1
`define JMC_ILAS_SUBCLASSV 3'h1
`define JMC_ILAS_OCTETS 14
`define JMC_MAX_K 6'h20

`endif

//--- jmc_rx_model.sv
`timescale 1ns/1ns

// Lane receiver on the far side; it can stall outright or take a word only every other cycle.
module jmc_rx_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [23:0] lane_data_i,
  input wire logic lane_valid_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic lane_ready_o
);
  // Every word taken, in arrival order, for the bench to judge.
  logic [23:0] got[$];

  // Ready is registered, as a real receiver would present it.
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      lane_ready_o <= 1'b0;
    else
      lane_ready_o <= !stall_i && !(slow_i && lane_ready_o);
  end

  // A word is taken only at an edge where both valid and ready are high.
  always @(posedge ref_clk_i)
  begin
    if (!rst_i && lane_valid_i && lane_ready_o)
      got.push_back(lane_data_i);
  end
endmodule

//--- test_jesd_mode_and_ilas_parameter_config.sv
`timescale 1ns/1ns
`include "jmc_regs.svh"

// Self-checking bench for the mode decoder, alignment octets and sample path.
module test_jesd_mode_and_ilas_parameter_config;
  import jmc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  jmc_pair_t ain_i = '0;
  jmc_pair_t bin_i = '0;
  logic samp_valid_i = 1'b0;
  logic samp_ready_o;
  logic [23:0] lane_data_o;
  logic lane_valid_o;
  logic lane_ready_i;
  logic ilas_rd_i = 1'b0;
  logic ilas_link_i = 1'b0;
  logic [2:0] ilas_lane_i = 3'h0;
  logic [3:0] ilas_idx_i = 4'h0;
  logic [7:0] ilas_octet_o;
  logic ilas_valid_o;
  logic [15:0] lane_en_o;
  logic des_o;
  logic ddc_en_o;
  logic [4:0] decim_o;
  logic [4:0] serdes_mult_o;
  logic pll_bypass_o;
  logic stall = 1'b1;
  logic slow = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc_cnt = 0;

  // Clock of 50 MHz.
  always #10 ref_clk_i = ~ref_clk_i;

  jmc_config #(.FIFO_DEPTH(8)) i_jmc_config (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .ain_i(ain_i), .bin_i(bin_i), .samp_valid_i(samp_valid_i), .samp_ready_o(samp_ready_o),
    .lane_data_o(lane_data_o), .lane_valid_o(lane_valid_o), .lane_ready_i(lane_ready_i),
    .ilas_rd_i(ilas_rd_i), .ilas_link_i(ilas_link_i), .ilas_lane_i(ilas_lane_i), .ilas_idx_i(ilas_idx_i),
    .ilas_octet_o(ilas_octet_o), .ilas_valid_o(ilas_valid_o), .lane_en_o(lane_en_o), .des_o(des_o),
    .ddc_en_o(ddc_en_o), .decim_o(decim_o), .serdes_mult_o(serdes_mult_o), .pll_bypass_o(pll_bypass_o));

  jmc_rx_model i_jmc_rx_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .lane_data_i(lane_data_o),
    .lane_valid_i(lane_valid_o), .stall_i(stall), .slow_i(slow), .lane_ready_o(lane_ready_i));

  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("Checks done %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // A hang is cut short well above the under two hundred cycles the run needs.
  always @(posedge ref_clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // Case inequality so an unknown never passes for a match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write cycle; strobe lowered at the next edge.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = reg_rdata_o;
  endtask

  // Requests one alignment octet and judges octet and valid in the answer cycle.
  task automatic ilas(input logic lk, input logic [2:0] ln, input logic [3:0] ix, input logic [7:0] eo,
    input logic ev);
    @(posedge ref_clk_i);
    ilas_rd_i <= 1'b1;
    ilas_link_i <= lk;
    ilas_lane_i <= ln;
    ilas_idx_i <= ix;
    @(posedge ref_clk_i);
    ilas_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(32'(ilas_octet_o), 32'(eo));
    chk(32'(ilas_valid_o), 32'(ev));
  endtask

  // Offers pair k and holds it until an edge that finds ready high.
  task automatic push(input logic [11:0] k);
    logic r;
    ain_i <= '{odd: 12'h300 + k, even: 12'h100 + k};
    bin_i <= '{odd: 12'h400 + k, even: 12'h200 + k};
    samp_valid_i <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(negedge ref_clk_i);
      r = samp_ready_o;
      @(posedge ref_clk_i);
      if (r)
        break;
    end
  endtask

  // Derived outputs for six of the modes, checked one table row at a time.
  task automatic t_modes();
    logic [4:0] md [6] = '{5'd0, 5'd2, 5'd9, 5'd12, 5'd15, 5'd17};
    // Packed as {single, down-converter in use, decimation[4:0], lane ratio times 4[4:0]}.
    logic [11:0] ex [6] = '{12'h830, 12'h030, 12'h44A, 12'h484, 12'h614, 12'h825};
    for (int i = 0; i < 6; i++)
    begin
      reg_wr(`JMC_OFS_MODE, 32'(md[i]));
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(32'(des_o), 32'(ex[i][11]));
      chk(32'(decim_o), 32'(ex[i][9:5]));
      chk(32'(serdes_mult_o), 32'(ex[i][4:0]));
      chk(32'(pll_bypass_o), 32'(ex[i][4:0] == 5'd4));
      chk(32'(ddc_en_o), 32'(ex[i][10]));
    end
  endtask

  // One-link mode: full octet set with checksum, refusals, lanes and a read-only write.
  task automatic t_ilas();
    logic [7:0] oc [13] = '{8'h5A, 8'h00, 8'h00, 8'h80, 8'h07, 8'h02, 8'h03, 8'h0E, 8'h2F, 8'h20, 8'h00, 8'h00, 8'h00};
    logic [7:0] sum;
    logic [31:0] d;
    // Field values, not octets: DID, SCR, F-1, K-1, M-1, N-1, N'-1 and both version fields.
    sum = 8'h5A + 8'h01 + 8'h07 + 8'h02 + 8'h03 + 8'h0E + 8'h0F + 8'h01 + 8'h01;
    reg_wr(`JMC_OFS_DEVID, 32'h5A);
    reg_wr(`JMC_OFS_KLEN, 32'h02);
    reg_wr(`JMC_OFS_LINKCTL, 32'h3);
    reg_wr(`JMC_OFS_MODE, 32'd15);
    repeat (2) @(posedge ref_clk_i);
    for (int i = 0; i < 13; i++)
    begin
      ilas(1'b0, 3'h0, 4'(i), oc[i], 1'b1);
    end
    ilas(1'b0, 3'h0, 4'hD, sum, 1'b1);
    ilas(1'b0, 3'h0, 4'hE, 8'h00, 1'b0);
    // A refused link still shows the octet; only the valid flag refuses it.
    ilas(1'b1, 3'h0, 4'h0, 8'h5A, 1'b0);
    chk(32'(lane_en_o), 32'h0001);
    reg_wr(`JMC_OFS_CHKSUM, 32'hFF);
    reg_rd(`JMC_OFS_CHKSUM, d);
    chk(d, 32'(sum));
    reg_wr(`JMC_OFS_MODE, 32'd0);
    repeat (2) @(posedge ref_clk_i);
    chk(32'(lane_en_o), 32'h0F0F);
    ilas(1'b1, 3'h3, 4'h2, 8'h03, 1'b1);
    ilas(1'b1, 3'h3, 4'h7, 8'h0B, 1'b1);
  endtask

  // Fills the buffer against a stalled receiver, then drains it slowly.
  task automatic t_stream();
    reg_wr(`JMC_OFS_LINKCTL, 32'h2);
    reg_wr(`JMC_OFS_MODE, 32'd2);
    repeat (2) @(posedge ref_clk_i);
    for (int k = 0; k < 8; k++)
      push(12'(k));
    samp_valid_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(32'(samp_ready_o), 32'h0);
    chk(32'(lane_valid_o), 32'h1);
    slow = 1'b1;
    stall = 1'b0;
    for (int n = 0; n < 100 && i_jmc_rx_model.got.size() < 8; n++)
      @(posedge ref_clk_i);
    // The last pop lands on that edge, so the flags are looked at once settled.
    @(negedge ref_clk_i);
    for (int k = 0; k < 8; k++)
      chk(32'(i_jmc_rx_model.got[k]), {8'h00, 12'h200 + 12'(k), 12'h100 + 12'(k)});
    chk(32'(lane_valid_o), 32'h0);
    slow = 1'b0;
    reg_wr(`JMC_OFS_INMUX, 32'h1);
    one_word(12'h8, {12'h108, 12'h208});
    reg_wr(`JMC_OFS_MODE, 32'd0);
    reg_wr(`JMC_OFS_INMUX, 32'h2);
    one_word(12'h9, {12'h409, 12'h209});
    reg_wr(`JMC_OFS_INMUX, 32'h0);
    one_word(12'hA, {12'h30A, 12'h10A});
  endtask

  // First scrambled word from the all-ones seed, 1 + x^14 + x^15, MSB first.
  task automatic t_scramble();
    logic [14:0] h;
    logic [23:0] d;
    logic [23:0] s;
    h = 15'h7FFF;
    d = {12'h20B, 12'h10B};
    for (int i = 23; i >= 0; i--)
    begin
      s[i] = d[i] ^ h[13] ^ h[14];
      h = {h[13:0], s[i]};
    end
    reg_wr(`JMC_OFS_MODE, 32'd2);
    reg_wr(`JMC_OFS_LINKCTL, 32'h3);
    one_word(12'hB, s);
  endtask

  // Sends one pair and compares the single word the receiver takes.
  task automatic one_word(input logic [11:0] k, input logic [23:0] exp);
    int n0;
    n0 = i_jmc_rx_model.got.size();
    repeat (2) @(posedge ref_clk_i);
    push(k);
    samp_valid_i <= 1'b0;
    for (int n = 0; n < 20 && i_jmc_rx_model.got.size() == n0; n++)
      @(posedge ref_clk_i);
    chk(32'(i_jmc_rx_model.got[n0]), 32'(exp));
  endtask

  // Reset values, an unmapped read, then the scenarios in turn.
  initial
  begin
    logic [31:0] d;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    reg_rd(`JMC_OFS_KLEN, d);
    chk(d, 32'h1F);
    reg_rd(`JMC_OFS_DEVID, d);
    chk(d, 32'h0);
    reg_rd(8'h20, d);
    chk(d, 32'h0);
    chk(32'(lane_en_o), 32'h0);
    t_modes();
    t_ilas();
    t_stream();
    t_scramble();
    test_done();
  end
endmodule
